// file: hw/dagf_core.sv
// Data address generator, pointer pairs and arithmetic flag register.
`include "dagf_map.svh"

// Contract
// - Bank access bit one: address is bank value joined with address byte.
// - Bank access bit zero: address byte selects an access bank location.
// - Full address moves use their 12-bit address and ignore the bank value.
// - Destination bit one writes the operand, zero the working register.
// - Calls and jumps take a 20-bit program address from the opcode.
// - Three pointer pairs of 12 bits; high byte's upper nibble unused.
// - Plain indirect operand accesses the pointed location, pointer unchanged.
// - Indirect accesses use the full pointer; bank value and bit ignored.
// - Post-decrement and post-increment access, then step pointer by one.
// - Pre-increment steps the pointer first, then accesses the new location.
// - W-offset adds signed working value; neither pointer nor W changes.
// - Pointer steps span all 12 bits, carrying between the two bytes.
// - Pointer steps never touch any arithmetic flag.
// - Indirect read landing on a virtual operand returns 00h.
// - Indirect write landing on a virtual operand does nothing; a stepping operand still steps its pointer.
// - Virtual write into a pointer pair stores the value without stepping.
// - Indexed literal offset mode exists only with the extended set enabled.
// - Extended set, bank bit zero, byte up to 5Fh: third pointer plus byte.
// - Flag updates win over a result written into the flag register.
module dagf_core
  import dagf_pkg::*;
(
  // Clock and reset.
  input logic ref_clk,
  input logic rst_n,
  // Configuration and core state from the execute stage.
  input logic extended_set_enable,
  input logic [3:0] bank_select_value,
  input logic [7:0] w_value,
  // Decoded request.
  input logic req_valid,
  input dagf_mode_type req_mode,
  input logic [7:0] req_addr_byte,
  input logic req_bank_access,
  input logic [11:0] req_full_addr,
  input logic [19:0] req_branch_addr,
  input logic req_dest,
  input logic req_read,
  input logic req_write,
  input logic [7:0] req_wdata,
  // Arithmetic operands of the request.
  input logic req_alu,
  input logic [7:0] alu_a,
  input logic [7:0] alu_b,
  input logic alu_cin,
  input logic alu_sub,
  // Data RAM.
  output logic [11:0] mem_addr,
  output logic mem_rd_en,
  output logic mem_wr_en,
  output logic [7:0] mem_wdata,
  input logic [7:0] mem_rdata,
  // Answers to the execute stage.
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic w_wr_en,
  output logic [7:0] w_wdata,
  output logic branch_valid,
  output logic [19:0] branch_target,
  output logic [7:0] alu_flags
);

  localparam dagf_state_type RESET_STATE = '{
    ptr: {3{`DAGF_PTR_RESET}},
    flags: `DAGF_FLAGS_RESET,
    default: '0
  };

  dagf_state_type s;
  dagf_state_type next_s;
  logic [11:0] tgt;
  logic [11:0] eff;
  logic [11:0] upd;
  logic [1:0] idx;
  logic via_ptr;
  logic null_acc;
  logic op_rd;
  logic op_wr;
  logic [7:0] b_eff;
  logic [7:0] wr_val;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [4:0] alu_new;

  // True for any location of the pointer block region.
  function automatic logic in_region(input logic [11:0] a);
    in_region = (a >= `DAGF_REGION_LO) && (a <= `DAGF_REGION_HI);
  endfunction

  // Pointer pair that owns a location of the region.
  function automatic logic [1:0] ptr_of(input logic [11:0] a);
    case (a[4:3])
      `DAGF_SEL_ZERO: ptr_of = 2'h0;
      `DAGF_SEL_ONE: ptr_of = 2'h1;
      `DAGF_SEL_TWO: ptr_of = 2'h2;
      default: ptr_of = 2'h0;
    endcase
  endfunction

  // Virtual operands occupy the five upper offsets of each block.
  function automatic logic is_virt(input logic [11:0] a);
    is_virt = in_region(a) && (a[2:0] >= `DAGF_OFS_WOFS);
  endfunction

  // Physical pointer bytes live at the high and low offsets.
  function automatic logic is_ptr_byte(input logic [11:0] a);
    is_ptr_byte = in_region(a) &&
      ((a[2:0] == `DAGF_OFS_HIGH) || (a[2:0] == `DAGF_OFS_LOW));
  endfunction

  // Next-state logic: address resolution, pointer steps, flags, strobes.
  always_comb
  begin
    next_s = s;
    tgt = 12'h000;
    eff = 12'h000;
    next_s.mem_rd_en = 1'b0;
    next_s.mem_wr_en = 1'b0;
    next_s.w_wr_en = 1'b0;
    next_s.branch_valid = 1'b0;
    next_s.rd_pending = 1'b0;
    next_s.rd_local = 1'b0;
    next_s.rd_valid = s.rd_pending;
    if (s.rd_pending)
    begin
      next_s.rd_data = s.rd_local ? s.rd_local_data : mem_rdata;
    end
    // Adder; subtraction adds the inverted operand with carry as no-borrow.
    b_eff = alu_sub ? ~alu_b : alu_b;
    sum9 = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, alu_cin};
    sum5 = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_cin};
    alu_new[`DAGF_FLAG_N] = sum9[7];
    alu_new[`DAGF_FLAG_V] = (alu_a[7] == b_eff[7]) &&
      (sum9[7] != alu_a[7]);
    alu_new[`DAGF_FLAG_Z] = (sum9[7:0] == 8'h00);
    alu_new[`DAGF_FLAG_H] = sum5[4];
    alu_new[`DAGF_FLAG_C] = sum9[8];
    wr_val = req_alu ? sum9[7:0] : req_wdata;
    // Operand address before any virtual operand's pointer is applied.
    case (req_mode)
      DAGF_MODE_DIRECT:
      begin
        if (req_bank_access)
        begin
          tgt = {bank_select_value, req_addr_byte};
        end
        else if (extended_set_enable &&
          (req_addr_byte <= `DAGF_LITERAL_LIMIT))
        begin
          tgt = s.ptr[2] + {4'h0, req_addr_byte};
        end
        else if (req_addr_byte >= `DAGF_ACCESS_SPLIT)
        begin
          tgt = {`DAGF_PAGE_HIGH, req_addr_byte};
        end
        else
        begin
          tgt = {`DAGF_PAGE_LOW, req_addr_byte};
        end
      end
      DAGF_MODE_FULL: tgt = req_full_addr;
      default: tgt = 12'h000;
    endcase
    // Virtual operands turn into a pointer access with an optional step.
    idx = ptr_of(tgt);
    via_ptr = is_virt(tgt) && (req_mode != DAGF_MODE_BRANCH);
    upd = s.ptr[idx];
    eff = tgt;
    if (via_ptr)
    begin
      case (tgt[2:0])
        `DAGF_OFS_POST_INC:
        begin
          eff = s.ptr[idx];
          upd = s.ptr[idx] + 12'h001;
        end
        `DAGF_OFS_POST_DEC:
        begin
          eff = s.ptr[idx];
          upd = s.ptr[idx] - 12'h001;
        end
        `DAGF_OFS_PRE_INC:
        begin
          upd = s.ptr[idx] + 12'h001;
          eff = upd;
        end
        `DAGF_OFS_WOFS: eff = s.ptr[idx] + {{4{w_value[7]}}, w_value};
        default: eff = s.ptr[idx];
      endcase
    end
    null_acc = via_ptr && is_virt(eff);
    op_rd = req_valid && req_read && (req_mode != DAGF_MODE_BRANCH);
    op_wr = req_valid && req_write && ((req_mode == DAGF_MODE_FULL) ||
      ((req_mode == DAGF_MODE_DIRECT) && req_dest));
    // Program address of calls and jumps.
    if (req_valid && (req_mode == DAGF_MODE_BRANCH))
    begin
      next_s.branch_valid = 1'b1;
      next_s.branch_target = req_branch_addr;
    end
    // Results bound for the working register.
    if (req_valid && req_write && (req_mode == DAGF_MODE_DIRECT) && !req_dest)
    begin
      next_s.w_wr_en = 1'b1;
      next_s.w_wdata = wr_val;
    end
    // Pointer step; a write landing on a pointer pair suppresses it.
    if (req_valid && via_ptr && !(op_wr && is_ptr_byte(eff)))
    begin
      next_s.ptr[idx] = upd;
    end
    // Only arithmetic requests and flag register writes touch the flags, never a pointer step.
    if (req_valid && req_alu)
    begin
      next_s.flags = alu_new;
    end
    // Read path: virtual targets give zero, local registers answer here.
    if (op_rd)
    begin
      next_s.rd_pending = 1'b1;
      if (null_acc)
      begin
        next_s.rd_local = 1'b1;
        next_s.rd_local_data = 8'h00;
      end
      else if (is_ptr_byte(eff))
      begin
        next_s.rd_local = 1'b1;
        next_s.rd_local_data = (eff[2:0] == `DAGF_OFS_HIGH) ?
          {4'h0, s.ptr[ptr_of(eff)][11:8]} : s.ptr[ptr_of(eff)][7:0];
      end
      else if (eff == `DAGF_FLAGS_ADDR)
      begin
        next_s.rd_local = 1'b1;
        next_s.rd_local_data = {3'h0, s.flags};
      end
      else
      begin
        next_s.mem_rd_en = 1'b1;
        next_s.mem_addr = eff;
      end
    end
    // Write path; a virtual target swallows the write.
    if (op_wr && !null_acc)
    begin
      if (is_ptr_byte(eff))
      begin
        if (eff[2:0] == `DAGF_OFS_HIGH)
        begin
          next_s.ptr[ptr_of(eff)][11:8] = wr_val[3:0];
        end
        else
        begin
          next_s.ptr[ptr_of(eff)][7:0] = wr_val;
        end
      end
      else if (eff == `DAGF_FLAGS_ADDR)
      begin
        if (!req_alu)
        begin
          next_s.flags = wr_val[4:0];
        end
      end
      else
      begin
        next_s.mem_wr_en = 1'b1;
        next_s.mem_addr = eff;
        next_s.mem_wdata = wr_val;
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s <= RESET_STATE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign mem_addr = s.mem_addr;
  assign mem_rd_en = s.mem_rd_en;
  assign mem_wr_en = s.mem_wr_en;
  assign mem_wdata = s.mem_wdata;
  assign rd_valid = s.rd_valid;
  assign rd_data = s.rd_data;
  assign w_wr_en = s.w_wr_en;
  assign w_wdata = s.w_wdata;
  assign branch_valid = s.branch_valid;
  assign branch_target = s.branch_target;
  assign alu_flags = {3'h0, s.flags};

  // Signed reference for the overflow check.
  logic [9:0] sgn_ref;
  assign sgn_ref = {alu_a[7], alu_a[7], alu_a} + {b_eff[7], b_eff[7], b_eff} +
    {9'h000, alu_cin};

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // A plain direct access that reaches RAM.
  sequence direct_ram_rd;
    req_valid && req_read && (req_mode == DAGF_MODE_DIRECT) && !is_virt(tgt)
      && !is_ptr_byte(tgt) && (tgt != `DAGF_FLAGS_ADDR);
  endsequence

  // An indirect read whose pointer lands on another virtual operand.
  sequence null_rd_req;
    req_valid && req_read && via_ptr && is_virt(eff);
  endsequence

  AST_NEG_FLAG: assert property (
    req_valid && req_alu |=> alu_flags[`DAGF_FLAG_N] == $past(sum9[7]))
    else $error("negative flag does not follow result sign");
  AST_OVERFLOW_FLAG: assert property (
    req_valid && req_alu |=>
      alu_flags[`DAGF_FLAG_V] == $past(sgn_ref[8] != sgn_ref[7]))
    else $error("overflow flag wrong");
  AST_ZERO_FLAG: assert property (
    req_valid && req_alu |=>
      alu_flags[`DAGF_FLAG_Z] == ($past(alu_a) + $past(b_eff) +
      {7'h00, $past(alu_cin)} == 8'h00))
    else $error("zero flag wrong");
  AST_BANK_ADDR: assert property (
    direct_ram_rd and req_bank_access |=> mem_rd_en &&
      mem_addr == {$past(bank_select_value), $past(req_addr_byte)})
    else $error("banked address wrong");
  AST_ACCESS_ADDR: assert property (
    direct_ram_rd and !req_bank_access and !extended_set_enable |=>
      mem_addr[11:8] == (($past(req_addr_byte) >= 8'h60) ? 4'hf : 4'h0))
    else $error("access bank page wrong");
  AST_FULL_ADDR: assert property (
    req_valid && req_read && req_mode == DAGF_MODE_FULL &&
      !in_region(req_full_addr) |=>
      mem_rd_en && mem_addr == $past(req_full_addr))
    else $error("full address not used directly");
  AST_DEST_W: assert property (
    req_valid && req_write && req_mode == DAGF_MODE_DIRECT && !req_dest
      |=> w_wr_en && !mem_wr_en)
    else $error("destination zero did not go to working register");
  AST_BRANCH: assert property (
    req_valid && req_mode == DAGF_MODE_BRANCH |=>
      branch_valid && branch_target == $past(req_branch_addr) && !mem_rd_en)
    else $error("branch target wrong");
  AST_INDIRECT_KEEP: assert property (
    req_valid && via_ptr && tgt[2:0] == `DAGF_OFS_INDIRECT && !req_write
      |=> s.ptr == $past(s.ptr))
    else $error("plain indirect changed a pointer");
  AST_POST_INC: assert property (
    req_valid && via_ptr && tgt[2:0] == `DAGF_OFS_POST_INC && !req_write
      |=> s.ptr[$past(idx)] == $past(s.ptr[idx]) + 12'h001)
    else $error("post-increment step wrong");
  AST_PRE_INC: assert property (
    req_valid && req_read && via_ptr && !req_write &&
      tgt[2:0] == `DAGF_OFS_PRE_INC && !in_region(s.ptr[idx] + 12'h001)
      |=> mem_addr == s.ptr[$past(idx)])
    else $error("pre-increment did not use updated pointer");
  AST_WOFS: assert property (
    req_valid && req_read && via_ptr && !req_write &&
      tgt[2:0] == `DAGF_OFS_WOFS && !in_region(eff) |=>
      s.ptr == $past(s.ptr) &&
      mem_addr == $past(s.ptr[idx]) + {{4{$past(w_value[7])}}, $past(w_value)})
    else $error("w-offset access wrong");
  AST_CARRY_WRAP: assert property (
    req_valid && via_ptr && tgt[2:0] == `DAGF_OFS_POST_INC && !req_write
      && s.ptr[idx][7:0] == 8'hff |=>
      s.ptr[$past(idx)][11:8] == $past(s.ptr[idx][11:8]) + 4'h1)
    else $error("low byte wrap did not carry");
  AST_FLAGS_KEEP: assert property (
    req_valid && via_ptr && !req_alu && !req_write |=> $stable(alu_flags))
    else $error("pointer step altered flags");
  AST_NULL_READ: assert property (
    null_rd_req |=> !mem_rd_en ##1 rd_valid && rd_data == 8'h00)
    else $error("virtual read did not return zero");
  AST_NULL_WRITE: assert property (
    op_wr && via_ptr && is_virt(eff) |=> !mem_wr_en)
    else $error("virtual write was not dropped");
  AST_LITERAL_OFS: assert property (
    direct_ram_rd and !req_bank_access and extended_set_enable
      and req_addr_byte <= 8'h5f |=>
      mem_addr == $past(s.ptr[2]) + {4'h0, $past(req_addr_byte)})
    else $error("indexed literal offset address wrong");
  AST_FLAG_PRIORITY: assert property (
    req_valid && req_alu && req_write && req_mode == DAGF_MODE_FULL &&
      req_full_addr == `DAGF_FLAGS_ADDR |=>
      alu_flags[4:0] == $past(alu_new) && !mem_wr_en)
    else $error("result overrode flag update");

endmodule

// file: hw/dagf_map.svh
// Address map, field positions, reset values and access bank limits.
`ifndef DAGF_MAP_SVH
`define DAGF_MAP_SVH

// Special-register region that holds the three pointer blocks.
`define DAGF_REGION_LO 12'hfd8
`define DAGF_REGION_HI 12'hfef
`define DAGF_FLAGS_ADDR 12'hfd8

// Offsets inside one eight-location pointer block.
`define DAGF_OFS_INDIRECT 3'h7
`define DAGF_OFS_POST_INC 3'h6
`define DAGF_OFS_POST_DEC 3'h5
`define DAGF_OFS_PRE_INC 3'h4
`define DAGF_OFS_WOFS 3'h3
`define DAGF_OFS_HIGH 3'h2
`define DAGF_OFS_LOW 3'h1

// Block select bits (address bits 4:3) of each pointer pair.
`define DAGF_SEL_ZERO 2'h1
`define DAGF_SEL_ONE 2'h0
`define DAGF_SEL_TWO 2'h3

// Access bank split and indexed literal offset limit.
`define DAGF_ACCESS_SPLIT 8'h60
`define DAGF_LITERAL_LIMIT 8'h5f
`define DAGF_PAGE_LOW 4'h0
`define DAGF_PAGE_HIGH 4'hf

// Flag positions inside the flag register.
`define DAGF_FLAG_N 4
`define DAGF_FLAG_V 3
`define DAGF_FLAG_Z 2
`define DAGF_FLAG_H 1
`define DAGF_FLAG_C 0

// Reset values.
`define DAGF_PTR_RESET 12'h000
`define DAGF_FLAGS_RESET 5'h00

`endif

// file: hw/dagf_pkg.sv
// Types shared by the address generator and flag logic.
package dagf_pkg;

  typedef enum logic [1:0] {
    DAGF_MODE_DIRECT = 2'b00,
    DAGF_MODE_FULL = 2'b01,
    DAGF_MODE_BRANCH = 2'b10
  } dagf_mode_type;

  typedef struct packed {
    logic [2:0][11:0] ptr;
    logic [4:0] flags;
    logic [11:0] mem_addr;
    logic mem_rd_en;
    logic mem_wr_en;
    logic [7:0] mem_wdata;
    logic rd_pending;
    logic rd_local;
    logic [7:0] rd_local_data;
    logic rd_valid;
    logic [7:0] rd_data;
    logic w_wr_en;
    logic [7:0] w_wdata;
    logic branch_valid;
    logic [19:0] branch_target;
  } dagf_state_type;

endpackage

// file: tb/dagf_ram_model.sv
// Behavioural data RAM that answers the address generator.
module dagf_ram_model
(
  // Clock.
  input wire logic ref_clk,
  // RAM port.
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd_en,
  input wire logic mem_wr_en,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [4096];
  logic [7:0] last = 8'h00;
  logic [11:0] k;

  // Fill every location with a pattern derived from its address.
  initial
  begin
    for (int i = 0; i < 4096; i++)
    begin
      k = 12'(i);
      mem[i] = k[7:0] ^ {k[11:8], k[11:8]};
    end
  end

  // Data is valid only while selected; otherwise it shows a changed value.
  always_comb
  begin
    if (mem_rd_en)
      mem_rdata = mem[mem_addr];
    else
      mem_rdata = ~last;
  end

  // A write lands at the edge, after the same cycle's read.
  always @(posedge ref_clk)
  begin
    if (mem_rd_en)
      last <= mem[mem_addr];
    if (mem_wr_en)
      mem[mem_addr] <= mem_wdata;
  end
endmodule

// file: tb/dagf_core_bench.sv
// Self-checking bench for the data address generator and flag logic.
module dagf_core_bench
  import dagf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, rst_n, extended_set_enable, req_valid, req_bank_access;
  logic req_dest, req_read, req_write, req_alu, alu_cin, alu_sub;
  logic mem_rd_en, mem_wr_en, rd_valid, w_wr_en, branch_valid;
  logic [3:0] bank_select_value;
  logic [7:0] w_value, req_addr_byte, req_wdata, alu_a, alu_b, mem_wdata;
  logic [7:0] mem_rdata, rd_data, w_wdata, alu_flags;
  logic [11:0] req_full_addr, mem_addr;
  logic [19:0] req_branch_addr, branch_target;
  dagf_mode_type req_mode;
  int err_count = 0;
  int num_checks = 0;
  logic g_mr, g_mw, g_ww, g_br;
  logic [11:0] g_ma;
  logic [7:0] g_md, g_w, g_rd;
  // Arithmetic cases: a, b, carry in, subtract, result, flags.
  logic [33:0] tv [4] = '{
    {8'h12, 8'h34, 2'h0, 8'h46, 8'h00},
    {8'h7f, 8'h01, 2'h0, 8'h80, 8'h1a},
    {8'hff, 8'h01, 2'h0, 8'h00, 8'h07},
    {8'h80, 8'h01, 2'h3, 8'h7f, 8'h09}};

  dagf_core uut (
    .ref_clk, .rst_n, .extended_set_enable, .bank_select_value, .w_value,
    .req_valid, .req_mode, .req_addr_byte, .req_bank_access, .req_full_addr,
    .req_branch_addr, .req_dest, .req_read, .req_write, .req_wdata,
    .req_alu, .alu_a, .alu_b, .alu_cin, .alu_sub, .mem_addr, .mem_rd_en,
    .mem_wr_en, .mem_wdata, .mem_rdata, .rd_valid, .rd_data, .w_wr_en,
    .w_wdata, .branch_valid, .branch_target, .alu_flags
  );

  dagf_ram_model ram (
    .ref_clk, .mem_addr, .mem_rd_en, .mem_wr_en, .mem_wdata, .mem_rdata
  );

  // Clock at 100 MHz.
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Initial RAM contents as the model fills them.
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  // Compares addresses, data and single bits.
  task automatic chk_addr(input logic [19:0] e, input logic [19:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_data(input logic [7:0] e, input logic [7:0] g);
    chk_addr({12'h000, e}, {12'h000, g});
  endtask

  task automatic chk_bit(input logic e, input logic g);
    chk_addr({19'h00000, e}, {19'h00000, g});
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask

  // Sets the core state levels at an edge.
  task automatic setup(input logic [3:0] b, input logic [7:0] w,
    input logic x);
    @(posedge ref_clk);
    bank_select_value <= b;
    w_value <= w;
    extended_set_enable <= x;
  endtask

  // Presents one request for a cycle and samples the answers.
  // The flag field holds bank access, dest, read, write and alu.
  task automatic issue(input dagf_mode_type m, input logic [19:0] a,
    input logic [4:0] f, input logic [7:0] wd);
    @(posedge ref_clk);
    req_mode <= m;
    req_addr_byte <= a[7:0];
    req_full_addr <= a[11:0];
    req_branch_addr <= a;
    {req_bank_access, req_dest, req_read, req_write, req_alu} <= f;
    req_wdata <= wd;
    req_valid <= 1'h1;
    @(posedge ref_clk);
    req_valid <= 1'h0;
    #1;
    {g_mr, g_mw, g_ma, g_md, g_ww, g_w, g_br} = {mem_rd_en, mem_wr_en,
      mem_addr, mem_wdata, w_wr_en, w_wdata, branch_valid};
    if (f[2])
    begin
      @(posedge ref_clk);
      #1;
      chk_bit(1'h1, rd_valid);
      g_rd = rd_data;
    end
  endtask

  task automatic wr_full(input logic [11:0] a, input logic [7:0] d);
    issue(DAGF_MODE_FULL, {8'h00, a}, 5'h02, d);
  endtask

  task automatic rd_full(input logic [11:0] a);
    issue(DAGF_MODE_FULL, {8'h00, a}, 5'h04, 8'h00);
  endtask

  // Loads the operands, then issues an arithmetic write.
  task automatic alu_op(input logic [17:0] v, input dagf_mode_type m,
    input logic [11:0] ad);
    @(posedge ref_clk);
    {alu_a, alu_b, alu_cin, alu_sub} <= v;
    issue(m, {8'h00, ad}, 5'h03, 8'h00);
  endtask

  // Cuts a hang short.
  initial
  begin
    #200000;
    err_count++;
    test_done();
  end

  // Main sequence.
  initial
  begin
    rst_n = 1'h0;
    {extended_set_enable, req_valid, req_bank_access, req_dest} = '0;
    {req_read, req_write, req_alu, alu_cin, alu_sub} = '0;
    {bank_select_value, w_value, req_addr_byte, req_wdata} = '0;
    {alu_a, alu_b, req_full_addr, req_branch_addr} = '0;
    req_mode = DAGF_MODE_DIRECT;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    setup(4'h5, 8'h00, 1'h0);
    issue(DAGF_MODE_DIRECT, 20'h00034, 5'h1e, 8'h6c);
    chk_addr(20'h00534, g_ma);
    chk_data(pat(12'h534), g_rd);
    chk_bit(1'h1, g_mw);
    chk_data(8'h6c, g_md);
    issue(DAGF_MODE_DIRECT, 20'h00020, 5'h0c, 8'h00);
    chk_addr(20'h00020, g_ma);
    chk_data(pat(12'h020), g_rd);
    issue(DAGF_MODE_DIRECT, 20'h00080, 5'h0c, 8'h00);
    chk_addr(20'h00f80, g_ma);
    issue(DAGF_MODE_DIRECT, 20'h00080, 5'h02, 8'h3c);
    chk_bit(1'h0, g_mw);
    chk_bit(1'h1, g_ww);
    chk_data(8'h3c, g_w);
    wr_full(12'h7a5, 8'h11);
    chk_addr(20'h007a5, g_ma);
    rd_full(12'h7a5);
    chk_bit(1'h1, g_mr);
    chk_data(8'h11, g_rd);
    issue(DAGF_MODE_BRANCH, 20'habcde, 5'h00, 8'h00);
    chk_bit(1'h1, g_br);
    chk_addr(20'habcde, branch_target);
    done_t("direct");
    alu_op(tv[1][33:16], DAGF_MODE_FULL, 12'hfd8);
    chk_data(8'h1a, alu_flags);
    wr_full(12'hfd8, 8'hff);
    chk_data(8'h1f, alu_flags);
    for (int i = 0; i < 4; i++)
    begin
      alu_op(tv[i][33:16], DAGF_MODE_DIRECT, 12'h000);
      chk_data(tv[i][15:8], g_w);
      chk_data(tv[i][7:0], alu_flags);
    end
    done_t("flags");
    wr_full(12'hfea, 8'hf0);
    wr_full(12'hfe9, 8'hff);
    rd_full(12'hfea);
    chk_data(8'h00, g_rd);
    issue(DAGF_MODE_DIRECT, 20'h000ef, 5'h0c, 8'h00);
    chk_addr(20'h000ff, g_ma);
    chk_data(pat(12'h0ff), g_rd);
    rd_full(12'hfe9);
    chk_data(8'hff, g_rd);
    rd_full(12'hfee);
    chk_addr(20'h000ff, g_ma);
    rd_full(12'hfea);
    chk_data(8'h01, g_rd);
    rd_full(12'hfe9);
    chk_data(8'h00, g_rd);
    chk_data(8'h09, alu_flags);
    rd_full(12'hfed);
    chk_addr(20'h00100, g_ma);
    rd_full(12'hfe9);
    chk_data(8'hff, g_rd);
    rd_full(12'hfea);
    chk_data(8'h00, g_rd);
    rd_full(12'hfec);
    chk_addr(20'h00100, g_ma);
    rd_full(12'hfe9);
    chk_data(8'h00, g_rd);
    chk_data(8'h09, alu_flags);
    setup(4'h5, 8'h80, 1'h0);
    rd_full(12'hfeb);
    chk_addr(20'h00080, g_ma);
    chk_bit(1'h0, g_ww);
    setup(4'h5, 8'h7f, 1'h0);
    rd_full(12'hfeb);
    chk_addr(20'h0017f, g_ma);
    rd_full(12'hfe9);
    chk_data(8'h00, g_rd);
    done_t("pointer");
    wr_full(12'hfe2, 8'h0f);
    wr_full(12'hfe1, 8'hef);
    rd_full(12'hfe7);
    chk_bit(1'h0, g_mr);
    chk_data(8'h00, g_rd);
    wr_full(12'hfe7, 8'h99);
    chk_bit(1'h0, g_mw);
    rd_full(12'hfe9);
    chk_data(8'h00, g_rd);
    wr_full(12'hfda, 8'h0f);
    wr_full(12'hfd9, 8'hd9);
    wr_full(12'hfdd, 8'h55);
    rd_full(12'hfd9);
    chk_data(8'h55, g_rd);
    rd_full(12'hfda);
    chk_data(8'h0f, g_rd);
    done_t("virtual");
    setup(4'h0, 8'h00, 1'h1);
    wr_full(12'hfda, 8'h02);
    wr_full(12'hfd9, 8'h00);
    issue(DAGF_MODE_DIRECT, 20'h0005f, 5'h0c, 8'h00);
    chk_addr(20'h0025f, g_ma);
    issue(DAGF_MODE_DIRECT, 20'h00060, 5'h0c, 8'h00);
    chk_addr(20'h00f60, g_ma);
    setup(4'h0, 8'h00, 1'h0);
    issue(DAGF_MODE_DIRECT, 20'h0005f, 5'h0c, 8'h00);
    chk_addr(20'h0005f, g_ma);
    done_t("literal");
    test_done();
  end
endmodule
